// *** rtl/byte_lane_and_command_decode.sv ***
// host port: byte lanes, register pointer and command decode
`timescale 1ns/1ps
`default_nettype none
module byte_lane_and_command_decode (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// slave access pins
	input wire logic chip_en_b,
	input wire logic rd_b,
	input wire logic wr_b,
	input wire logic section_select,
	input wire logic channel_select,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe,
	// dma side, from logic on this clock
	input wire logic dma_master,
	input wire logic dma_to_mem,
	input wire logic dma_strobe,
	input wire logic dma_addr_lsb,
	input wire logic swap_en,
	input wire logic swap_sel,
	input wire logic [7:0] dma_tx_byte,
	output logic [7:0] dma_rx_byte,
	output logic dma_rx_valid,
	// register file side
	input wire logic [7:0] reg_rd_data,
	output logic [3:0] reg_ptr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wr_data,
	output logic chan_a_sel,
	output logic dma_sel,
	output logic [host_port_pkg::ACT_W-1:0] chan_act
);

	// pin synchronisers
	logic [1:0] ce_s1_ff, ce_s2_ff, rd_s1_ff, rd_s2_ff, wr_s1_ff, wr_s2_ff;
	logic [1:0] sec_s1_ff, sec_s2_ff, ch_s1_ff, ch_s2_ff;
	logic [15:0] din_s1_ff, din_s2_ff;
	logic rd_prev_ff, wr_prev_ff;
	logic ce_sync, rd_sync, wr_sync, sec_sync, ch_sync;
	logic rd_act, wr_act, rd_start, wr_start;

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ce_s1_ff <= 2'h3;
			ce_s2_ff <= 2'h3;
			rd_s1_ff <= 2'h3;
			rd_s2_ff <= 2'h3;
			wr_s1_ff <= 2'h3;
			wr_s2_ff <= 2'h3;
			sec_s1_ff <= 2'h0;
			sec_s2_ff <= 2'h0;
			ch_s1_ff <= 2'h0;
			ch_s2_ff <= 2'h0;
			din_s1_ff <= 16'h0000;
			din_s2_ff <= 16'h0000;
			rd_prev_ff <= 1'b0;
			wr_prev_ff <= 1'b0;
		end else begin
			ce_s1_ff <= {ce_s1_ff[0], chip_en_b};
			ce_s2_ff <= {ce_s2_ff[0], ce_s1_ff[1]};
			rd_s1_ff <= {rd_s1_ff[0], rd_b};
			rd_s2_ff <= {rd_s2_ff[0], rd_s1_ff[1]};
			wr_s1_ff <= {wr_s1_ff[0], wr_b};
			wr_s2_ff <= {wr_s2_ff[0], wr_s1_ff[1]};
			sec_s1_ff <= {sec_s1_ff[0], section_select};
			sec_s2_ff <= {sec_s2_ff[0], sec_s1_ff[1]};
			ch_s1_ff <= {ch_s1_ff[0], channel_select};
			ch_s2_ff <= {ch_s2_ff[0], ch_s1_ff[1]};
			din_s1_ff <= data_in;
			din_s2_ff <= din_s1_ff;
			rd_prev_ff <= rd_act;
			wr_prev_ff <= wr_act;
		end
	end

	// bit 1 of each chain's second stage, the fourth flop, is the synchronised pin
	always_comb begin
		ce_sync = ce_s2_ff[1];
		rd_sync = rd_s2_ff[1];
		wr_sync = wr_s2_ff[1];
		sec_sync = sec_s2_ff[1];
		ch_sync = ch_s2_ff[1];
		rd_act = !ce_sync && !rd_sync && !dma_master;
		wr_act = !ce_sync && !wr_sync && !dma_master;
		rd_start = rd_act && !rd_prev_ff;
		wr_start = wr_act && !wr_prev_ff;
	end

	// command decode and inbound lane choice
	logic [7:0] in_byte;
	logic [3:0] dec_ptr;
	logic [host_port_pkg::ACT_W-1:0] dec_act;

	lane_steer u_lane (
		.bus_data(dma_master ? data_in : din_s2_ff),
		.dma_mode(dma_master),
		.swap_en(swap_en),
		.swap_sel(swap_sel),
		.addr_lsb(dma_addr_lsb),
		.in_byte(in_byte)
	);

	cmd_decode u_dec (
		.cmd_byte(in_byte),
		.reg_num(dec_ptr),
		.act_vec(dec_act)
	);

	// pointer sequencer, one pointer shared by both sections and channels
	host_port_pkg::ptr_state_t ptr_st_ff, nxt_ptr_st;
	logic [3:0] ptr_ff, nxt_ptr;
	logic [3:0] acc_ptr;
	logic [host_port_pkg::ACT_W-1:0] act_ff, nxt_act;
	logic wr_ff, nxt_wr, rd_ff, nxt_rd;
	logic [7:0] wdata_ff, nxt_wdata;
	logic chan_a_ff, nxt_chan_a, dma_sel_ff, nxt_dma_sel;
	logic [3:0] out_ptr_ff;

	always_comb begin
		nxt_ptr_st = ptr_st_ff;
		nxt_ptr = ptr_ff;
		acc_ptr = ptr_ff;
		nxt_act = '0;
		nxt_wr = 1'b0;
		nxt_rd = 1'b0;
		nxt_wdata = wdata_ff;
		nxt_chan_a = chan_a_ff;
		nxt_dma_sel = dma_sel_ff;
		if (rd_start || wr_start) begin
			nxt_dma_sel = !sec_sync;
			nxt_chan_a = sec_sync && ch_sync;
			case (ptr_st_ff)
				host_port_pkg::PTR_IDLE: begin
					// access at pointer zero: command write or status read
					if (wr_start) begin
						nxt_ptr = dec_ptr;
						nxt_act = dec_act;
						nxt_ptr_st = host_port_pkg::PTR_ARMED;
					end else begin
						nxt_rd = 1'b1;
					end
				end
				host_port_pkg::PTR_ARMED: begin
					// second access reaches the pointed register
					nxt_wr = wr_start;
					nxt_rd = rd_start;
					nxt_wdata = in_byte;
					nxt_ptr = host_port_pkg::PTR_RESET;
					nxt_ptr_st = host_port_pkg::PTR_IDLE;
				end
				default: begin
					nxt_ptr = host_port_pkg::PTR_RESET;
					nxt_ptr_st = host_port_pkg::PTR_IDLE;
				end
			endcase
		end
		if (nxt_wr || nxt_rd) begin
			acc_ptr = ptr_ff;
		end else if ((rd_act || wr_act) && !(rd_start || wr_start)) begin
			// hold the pointer while the strobe stands
			acc_ptr = out_ptr_ff;
		end else begin
			acc_ptr = nxt_ptr;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			ptr_st_ff <= host_port_pkg::PTR_IDLE;
			ptr_ff <= host_port_pkg::PTR_RESET;
			act_ff <= '0;
			wr_ff <= 1'b0;
			rd_ff <= 1'b0;
			wdata_ff <= 8'h00;
			chan_a_ff <= 1'b0;
			dma_sel_ff <= 1'b0;
		end else begin
			ptr_st_ff <= nxt_ptr_st;
			ptr_ff <= nxt_ptr;
			act_ff <= nxt_act;
			wr_ff <= nxt_wr;
			rd_ff <= nxt_rd;
			wdata_ff <= nxt_wdata;
			chan_a_ff <= nxt_chan_a;
			dma_sel_ff <= nxt_dma_sel;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_ptr_ff <= host_port_pkg::PTR_RESET;
		end else begin
			out_ptr_ff <= acc_ptr;
		end
	end

	// outbound lanes and dma capture
	logic [15:0] dout_ff, nxt_dout;
	logic oe_ff, nxt_oe;
	logic [7:0] dma_rx_ff, nxt_dma_rx;
	logic dma_rxv_ff, nxt_dma_rxv;

	always_comb begin
		nxt_dout = dout_ff;
		nxt_oe = 1'b0;
		nxt_dma_rx = dma_rx_ff;
		nxt_dma_rxv = 1'b0;
		if (dma_master) begin
			if (dma_to_mem) begin
				nxt_oe = 1'b1;
				nxt_dout = {dma_tx_byte, dma_tx_byte};
			end else if (dma_strobe) begin
				nxt_dma_rx = in_byte;
				nxt_dma_rxv = 1'b1;
			end
		end else if (rd_act) begin
			nxt_oe = 1'b1;
			nxt_dout = {reg_rd_data, reg_rd_data};
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			dout_ff <= 16'h0000;
			oe_ff <= 1'b0;
			dma_rx_ff <= 8'h00;
			dma_rxv_ff <= 1'b0;
		end else begin
			dout_ff <= nxt_dout;
			oe_ff <= nxt_oe;
			dma_rx_ff <= nxt_dma_rx;
			dma_rxv_ff <= nxt_dma_rxv;
		end
	end

	always_comb begin
		data_out = dout_ff;
		data_oe = oe_ff;
		dma_rx_byte = dma_rx_ff;
		dma_rx_valid = dma_rxv_ff;
		reg_ptr = out_ptr_ff;
		reg_wr = wr_ff;
		reg_rd = rd_ff;
		reg_wr_data = wdata_ff;
		chan_a_sel = chan_a_ff;
		dma_sel = dma_sel_ff;
		chan_act = act_ff;
	end

	// checks
	chk_pointer_clears: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(ptr_st_ff == host_port_pkg::PTR_ARMED && (rd_start || wr_start))
		|=> ptr_ff == 4'h0) else $error("pointer not cleared");
	chk_lanes_match: assert property (@(posedge ref_clk) disable iff (!rst_b)
		data_oe |-> data_out[15:8] == data_out[7:0])
		else $error("byte lanes differ");
	chk_read_dup: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(rd_act && !dma_master) |=> data_oe && data_out[7:0] == $past(reg_rd_data))
		else $error("slave read byte wrong");
	chk_dma_dup: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(dma_master && dma_to_mem) |=> data_out == {2{$past(dma_tx_byte)}})
		else $error("dma out byte wrong");
	chk_null_cmd: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wr_start && ptr_st_ff == host_port_pkg::PTR_IDLE
		&& in_byte[7:3] == 5'h00) |=> chan_act == '0)
		else $error("null command had effect");
	chk_ptr_load: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wr_start && ptr_st_ff == host_port_pkg::PTR_IDLE)
		|=> ptr_ff == {$past(in_byte[5:3]) == 3'h1, $past(in_byte[2:0])})
		else $error("pointer load wrong");
	chk_crc_eom: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wr_start && ptr_st_ff == host_port_pkg::PTR_IDLE
		&& in_byte[7:6] == 2'h3) |=> chan_act[host_port_pkg::ACT_RST_EOM])
		else $error("eom reset missing");
	chk_high_ius: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(wr_start && ptr_st_ff == host_port_pkg::PTR_IDLE
		&& in_byte[5:3] == 3'h7) |=> chan_act[host_port_pkg::ACT_RST_HIGH_IUS])
		else $error("ius reset missing");
	chk_dma_section: assert property (@(posedge ref_clk) disable iff (!rst_b)
		((rd_start || wr_start) && !sec_sync) |=> dma_sel && !chan_a_sel)
		else $error("section select wrong");
	chk_swap_odd: assert property (@(posedge ref_clk) disable iff (!rst_b)
		(dma_master && !dma_to_mem && dma_strobe && swap_en && swap_sel
		&& dma_addr_lsb) |=> dma_rx_byte == $past(data_in[15:8]))
		else $error("odd byte lane wrong");

endmodule
`default_nettype wire

// *** rtl/host_port_pkg.sv ***
// constants shared by the byte-lane and command decode block
package host_port_pkg;

	// command/pointer register fields
	localparam int unsigned PTR_LSB = 0;
	localparam int unsigned PTR_MSB = 2;
	localparam int unsigned CMD_LSB = 3;
	localparam int unsigned CMD_MSB = 5;
	localparam int unsigned CRC_LSB = 6;
	localparam int unsigned CRC_MSB = 7;
	localparam logic [3:0] PTR_RESET = 4'h0;
	localparam logic [3:0] PTR_HIGH_ADD = 4'h8;

	// command field encodings
	localparam logic [2:0] CMD_NULL = 3'h0;
	localparam logic [2:0] CMD_POINT_HIGH = 3'h1;
	localparam logic [2:0] CMD_RST_EXT_STATUS = 3'h2;
	localparam logic [2:0] CMD_SEND_ABORT = 3'h3;
	localparam logic [2:0] CMD_INT_NEXT_RX = 3'h4;
	localparam logic [2:0] CMD_RST_TX_INT = 3'h5;
	localparam logic [2:0] CMD_ERROR_RESET = 3'h6;
	localparam logic [2:0] CMD_RST_HIGH_IUS = 3'h7;

	// crc-reset field encodings
	localparam logic [1:0] CRC_NULL = 2'h0;
	localparam logic [1:0] CRC_RST_RX = 2'h1;
	localparam logic [1:0] CRC_RST_TX = 2'h2;
	localparam logic [1:0] CRC_RST_EOM = 2'h3;

	// pulse vector bit positions (one bit per channel action)
	localparam int unsigned ACT_RST_EXT_STATUS = 0;
	localparam int unsigned ACT_SEND_ABORT = 1;
	localparam int unsigned ACT_INT_NEXT_RX = 2;
	localparam int unsigned ACT_RST_TX_INT = 3;
	localparam int unsigned ACT_ERROR_RESET = 4;
	localparam int unsigned ACT_RST_HIGH_IUS = 5;
	localparam int unsigned ACT_RST_RX_CRC = 6;
	localparam int unsigned ACT_RST_TX_CRC = 7;
	localparam int unsigned ACT_RST_EOM = 8;
	localparam int unsigned ACT_W = 9;

	// pointer sequence states
	typedef enum logic [2:0] {
		PTR_IDLE = 3'b001,
		PTR_ARMED = 3'b010,
		PTR_DONE = 3'b100
	} ptr_state_t;

endpackage

// *** rtl/cmd_decode.sv ***
// decode of one command/pointer register byte into pointer and actions
`timescale 1ns/1ps
`default_nettype none
module cmd_decode (
	// written byte
	input wire logic [7:0] cmd_byte,
	// decoded result
	output logic [3:0] reg_num,
	output logic [host_port_pkg::ACT_W-1:0] act_vec
);

	logic [2:0] cmd_field;
	logic [1:0] crc_field;

	always_comb begin
		cmd_field = cmd_byte[host_port_pkg::CMD_MSB:host_port_pkg::CMD_LSB];
		crc_field = cmd_byte[host_port_pkg::CRC_MSB:host_port_pkg::CRC_LSB];
		reg_num = {1'b0, cmd_byte[host_port_pkg::PTR_MSB:host_port_pkg::PTR_LSB]};
		if (cmd_field == host_port_pkg::CMD_POINT_HIGH) begin
			reg_num = reg_num + host_port_pkg::PTR_HIGH_ADD;
		end
		act_vec = '0;
		case (cmd_field)
			host_port_pkg::CMD_RST_EXT_STATUS:
				act_vec[host_port_pkg::ACT_RST_EXT_STATUS] = 1'b1;
			host_port_pkg::CMD_SEND_ABORT:
				act_vec[host_port_pkg::ACT_SEND_ABORT] = 1'b1;
			host_port_pkg::CMD_INT_NEXT_RX:
				act_vec[host_port_pkg::ACT_INT_NEXT_RX] = 1'b1;
			host_port_pkg::CMD_RST_TX_INT:
				act_vec[host_port_pkg::ACT_RST_TX_INT] = 1'b1;
			host_port_pkg::CMD_ERROR_RESET:
				act_vec[host_port_pkg::ACT_ERROR_RESET] = 1'b1;
			host_port_pkg::CMD_RST_HIGH_IUS:
				act_vec[host_port_pkg::ACT_RST_HIGH_IUS] = 1'b1;
			default: begin
			end
		endcase
		case (crc_field)
			host_port_pkg::CRC_RST_RX:
				act_vec[host_port_pkg::ACT_RST_RX_CRC] = 1'b1;
			host_port_pkg::CRC_RST_TX:
				act_vec[host_port_pkg::ACT_RST_TX_CRC] = 1'b1;
			host_port_pkg::CRC_RST_EOM:
				act_vec[host_port_pkg::ACT_RST_EOM] = 1'b1;
			default: begin
			end
		endcase
	end

endmodule
`default_nettype wire

// *** rtl/lane_steer.sv ***
// byte lane selection for bytes coming into the device
`timescale 1ns/1ps
`default_nettype none
module lane_steer (
	// bus data and mode
	input wire logic [15:0] bus_data,
	input wire logic dma_mode,
	input wire logic swap_en,
	input wire logic swap_sel,
	input wire logic addr_lsb,
	// chosen byte
	output logic [7:0] in_byte
);

	always_comb begin
		in_byte = bus_data[7:0];
		if (dma_mode && swap_en) begin
			// swap-select one: even low lane, odd high lane
			if (swap_sel) begin
				in_byte = addr_lsb ? bus_data[15:8] : bus_data[7:0];
			end else begin
				in_byte = addr_lsb ? bus_data[7:0] : bus_data[15:8];
			end
		end
	end

endmodule
`default_nettype wire

// *** verif/host_mem_model.sv ***
// system memory on the dma side of the host port
`timescale 1ns/1ps
`default_nettype none
module host_mem_model #(
	parameter logic [15:0] INIT = 16'hb74c
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// dma bus view
	input wire logic dma_master,
	input wire logic dma_to_mem,
	input wire logic dma_addr_lsb,
	input wire logic [15:0] data_out,
	input wire logic data_oe,
	output logic [15:0] mem_data,
	output logic [15:0] mem_word
);
	logic rd_en;
	assign rd_en = dma_master & ~dma_to_mem;
	// when not driving, show the inverse so stale data never matches
	assign mem_data = rd_en ? mem_word : ~mem_word;
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			mem_word <= INIT;
		end else if (dma_master && dma_to_mem && data_oe) begin
			// own decode picks the byte from the address lsb
			if (dma_addr_lsb) begin
				mem_word[15:8] <= data_out[15:8];
			end else begin
				mem_word[7:0] <= data_out[7:0];
			end
		end
	end
endmodule
`default_nettype wire

// *** verif/byte_lane_and_command_decode_tb_top.sv ***
// self-checking bench for the host port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin \
	num_errors++; $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); end end
module byte_lane_and_command_decode_tb_top;
	logic ref_clk = 0, rst_b = 0, chip_en_b = 1, rd_b = 1, wr_b = 1;
	logic section_select = 1, channel_select = 1, dma_master = 0;
	logic dma_to_mem = 0, dma_strobe = 0, dma_addr_lsb = 0, swap_en = 0;
	logic swap_sel = 0;
	logic [7:0] dma_tx_byte = 8'h00;
	logic [15:0] host_data = 16'h0000, data_in, data_out, mem_data, mem_word;
	logic data_oe, dma_rx_valid, reg_wr, reg_rd, chan_a_sel, dma_sel;
	logic [7:0] dma_rx_byte, reg_rd_data, reg_wr_data, wr_data, rx_got;
	logic [3:0] reg_ptr, wr_ptr, rd_ptr;
	logic [8:0] chan_act, act_seen;
	logic [15:0] out_seen;
	int num_errors = 0, compares = 0, wr_cnt, rd_cnt, rx_cnt;
	logic [7:0] exp_b;
	logic [8:0] exp_act;
	always #5 ref_clk = ~ref_clk;
	assign reg_rd_data = {4'h9, reg_ptr};
	assign data_in = (dma_master && !dma_to_mem) ? mem_data : host_data;
	byte_lane_and_command_decode DUT (.ref_clk(ref_clk), .rst_b(rst_b),
		.chip_en_b(chip_en_b), .rd_b(rd_b), .wr_b(wr_b),
		.section_select(section_select), .channel_select(channel_select),
		.data_in(data_in), .data_out(data_out), .data_oe(data_oe),
		.dma_master(dma_master), .dma_to_mem(dma_to_mem),
		.dma_strobe(dma_strobe), .dma_addr_lsb(dma_addr_lsb),
		.swap_en(swap_en), .swap_sel(swap_sel), .dma_tx_byte(dma_tx_byte),
		.dma_rx_byte(dma_rx_byte), .dma_rx_valid(dma_rx_valid),
		.reg_rd_data(reg_rd_data), .reg_ptr(reg_ptr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wr_data(reg_wr_data), .chan_a_sel(chan_a_sel),
		.dma_sel(dma_sel), .chan_act(chan_act));
	host_mem_model mem (.ref_clk(ref_clk), .rst_b(rst_b),
		.dma_master(dma_master), .dma_to_mem(dma_to_mem),
		.dma_addr_lsb(dma_addr_lsb), .data_out(data_out), .data_oe(data_oe),
		.mem_data(mem_data), .mem_word(mem_word));
	// record what the block answers during each access
	always @(posedge ref_clk) begin
		if (reg_wr === 1'b1) begin
			wr_cnt++;
			wr_ptr = reg_ptr;
			wr_data = reg_wr_data;
		end
		if (reg_rd === 1'b1) begin
			rd_cnt++;
			rd_ptr = reg_ptr;
		end
		if (dma_rx_valid === 1'b1) begin
			rx_cnt++;
			rx_got = dma_rx_byte;
		end
		if (data_oe === 1'b1) out_seen = data_out;
		act_seen = act_seen | chan_act;
	end
	task automatic clr();
		wr_cnt = 0;
		rd_cnt = 0;
		rx_cnt = 0;
		act_seen = '0;
		out_seen = 16'h0000;
	endtask
	// one slave access; junk on the high lane, data on the low lane
	task automatic acc(input logic wr, input logic sec, input logic ch,
		input logic [7:0] b);
		@(negedge ref_clk);
		clr();
		section_select = sec;
		channel_select = ch;
		host_data = {~b, b};
		chip_en_b = 0;
		if (wr) wr_b = 0;
		else rd_b = 0;
		repeat (6) @(negedge ref_clk);
		chip_en_b = 1;
		wr_b = 1;
		rd_b = 1;
		repeat (3) @(negedge ref_clk);
	endtask
	task automatic test_done();
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		#100us;
		num_errors++;
		test_done();
	end
	initial begin
		repeat (6) @(negedge ref_clk);
		`CHK("reset strobes", 12'h000, {data_oe, reg_wr, reg_rd, chan_act})
		`CHK("reset select", 7'h00, {reg_ptr, dma_rx_valid, chan_a_sel, dma_sel})
		`CHK("reset data", 32'h0, {data_out, dma_rx_byte, reg_wr_data})
		rst_b = 1;
		repeat (3) @(negedge ref_clk);
		// pointer then write to every register, then an idle read
		for (int p = 0; p < 16; p++) begin
			acc(1, 1, p[0], {2'h0, (p > 7) ? 3'h1 : 3'h0, p[2:0]});
			`CHK("no side effect", 9'h0, act_seen)
			acc(1, 1, p[0], 8'hc3);
			`CHK("write count", 1, wr_cnt)
			`CHK("write pointer", p[3:0], wr_ptr)
			`CHK("write data low lane", 8'hc3, wr_data)
			acc(0, 1, p[0], 8'h00);
			`CHK("idle read pointer", 4'h0, rd_ptr)
			`CHK("idle read lanes", 16'h9090, out_seen)
			`CHK("channel a select", p[0], chan_a_sel)
		end
		// every command and crc code, each followed by the register access
		for (int i = 0; i < 8; i++) begin
			acc(1, 1, 0, {i[1:0], i[2:0], 3'h0});
			exp_act = ((i > 1) ? 9'h1 << (i - 2) : 9'h0)
				| ((i[1:0] != 0) ? 9'h1 << (5 + i[1:0]) : 9'h0);
			`CHK("command pulses", exp_act, act_seen)
			acc(0, 1, 0, 8'h00);
		end
		acc(1, 1, 0, 8'h05);
		acc(0, 1, 0, 8'h00);
		`CHK("pointed read", 4'h5, rd_ptr)
		`CHK("read count", 1, rd_cnt)
		`CHK("read both lanes", 16'h9595, out_seen)
		acc(0, 0, 1, 8'h00);
		`CHK("dma section select", 1'b1, dma_sel)
		// inbound dma lane choice for all swap settings
		dma_master = 1;
		for (int k = 0; k < 8; k++) begin
			@(negedge ref_clk);
			clr();
			{swap_en, swap_sel, dma_addr_lsb} = k[2:0];
			dma_strobe = 1;
			@(negedge ref_clk);
			dma_strobe = 0;
			repeat (2) @(negedge ref_clk);
			exp_b = (!k[2] || (k[1] ^ k[0])) ? 8'h4c : 8'hb7;
			`CHK("rx count", 1, rx_cnt)
			`CHK("rx lane", exp_b, rx_got)
		end
		// outbound dma to each memory byte, with a slave strobe refused
		dma_to_mem = 1;
		for (int a = 0; a < 2; a++) begin
			@(negedge ref_clk);
			clr();
			dma_addr_lsb = a[0];
			dma_tx_byte = a[0] ? 8'h6e : 8'h21;
			chip_en_b = 0;
			wr_b = 0;
			repeat (5) @(negedge ref_clk);
			chip_en_b = 1;
			wr_b = 1;
			`CHK("tx both lanes", {dma_tx_byte, dma_tx_byte}, out_seen)
			`CHK("slave refused", 0, wr_cnt)
		end
		`CHK("memory bytes", 16'h6e21, mem_word)
		// let the refused strobe leave the synchronisers first
		repeat (6) @(negedge ref_clk);
		dma_master = 0;
		dma_to_mem = 0;
		repeat (4) @(negedge ref_clk);
		test_done();
	end
endmodule
`default_nettype wire
